// ==== src/ccmp_pkg.sv ====
// constants shared by the counter parameter and multi-compare block
// assumes a single 20 MHz clock and a classic wishbone register port
// Contract
// - read enable returns parameter value and valid
// - write on execute rise, done afterwards
// - parameter 10001 masks compare events to tasks
// - parameter 10002 gates soft output, not direct
// - direction write takes effect at once; code refuses it with ERR_DIR_LOCK on the channel under check or compare
// - parameter 10009 stops frequency result
// - parameter 10010 stops rotation rate result
// - up to 100 signed compare values
// - direct mode drives output from hardware
// - direct pulse is length times 100 us
// - match raises done and reports index
// - count of matched entries kept and shown
// - failed request shows error flag and code
// - direct 0..3000 ms, soft 100 us..3000 ms; code takes a soft length of 0 as a level held until the compare enable drops
package ccmp_pkg;
  localparam int NCH       = 8;     // counter channels
  localparam int CH_W      = 3;
  localparam int TBL_DEPTH = 100;   // compare table entries
  localparam int IDX_W     = 7;
  // parameter numbers
  localparam logic [31:0] PID_EVT_MASK = 32'h0000_2711; // 10001
  localparam logic [31:0] PID_SOFT_OUT = 32'h0000_2712; // 10002
  localparam logic [31:0] PID_DIR      = 32'h0000_2718; // 10008
  localparam logic [31:0] PID_FREQ_OFF = 32'h0000_2719; // 10009
  localparam logic [31:0] PID_ROT_OFF  = 32'h0000_271A; // 10010
  // bit positions inside a channel's parameter word
  localparam int PB_EVT  = 0;
  localparam int PB_SOFT = 1;
  localparam int PB_DIR  = 2;
  localparam int PB_FREQ = 3;
  localparam int PB_ROT  = 4;
  localparam int PB_N    = 5;
  localparam logic [PB_N-1:0] PARAM_RST = 5'h00;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PID    = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam logic [7:0] REG_ECODE  = 8'h0C;
  localparam logic [7:0] REG_MCNT   = 8'h10;
  localparam logic [7:0] REG_CIDX   = 8'h14;
  localparam logic [7:0] REG_NUM    = 8'h18;
  localparam logic [7:0] REG_PLEN   = 8'h1C;
  localparam logic [7:0] REG_TIDX   = 8'h20;
  localparam logic [7:0] REG_TDATA  = 8'h24;
  localparam logic [7:0] REG_ISTS   = 8'h28;
  localparam logic [7:0] REG_IMASK  = 8'h2C;
  // control register fields
  localparam int CT_CH_LSB = 0;
  localparam int CT_RD_EN  = 3;
  localparam int CT_WR_EX  = 4;
  localparam int CT_WR_VAL = 5;
  localparam int CT_CMP_EN = 6;
  localparam int CT_HW     = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // interrupt status bits
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_WDONE = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_N     = 3;
  // error codes
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_BAD_PID  = 16'h0001;
  localparam logic [15:0] ERR_BAD_NUM  = 16'h0002;
  localparam logic [15:0] ERR_BAD_VAL  = 16'h0003;
  localparam logic [15:0] ERR_DIR_LOCK = 16'h0004;
  // timing: pulse unit and upper limit
  localparam int CLK_PERIOD_NS = 50;
  localparam int UNIT_US       = 100;
  localparam int UNIT_CYCLES   = (UNIT_US * 1000) / CLK_PERIOD_NS;
  localparam int MAX_MS        = 3000;
  localparam logic [15:0] MAX_UNITS = 16'((MAX_MS * 1000) / UNIT_US);
  localparam logic [31:0] DINT_MIN  = 32'h8000_0000;
  localparam logic [31:0] DINT_MAX  = 32'h7FFF_FFFF;
endpackage

// ==== src/ccmp_pulse_timer.sv ====
// output pulse timer counting in units of a prescaled clock
// assumes start is a one-cycle pulse; a zero length gives no pulse
`timescale 1ns/1ps
`default_nettype none
module ccmp_pulse_timer
  import ccmp_pkg::*;
#(
  parameter int UNIT_CLKS = UNIT_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_start,
  input  wire logic [15:0] i_units,
  output logic             o_active
);
  logic [15:0] pre_q, pre_d;     // cycles inside one unit
  logic [15:0] left_q, left_d;   // units still to run
  logic        act_q, act_d;

  // restart on every start so a new match extends the pulse
  always_comb begin
    pre_d  = pre_q;
    left_d = left_q;
    act_d  = act_q;
    if (i_start) begin
      pre_d  = 16'h0000;
      left_d = i_units;
      act_d  = (i_units != 16'h0000);
    end else if (act_q) begin
      if (pre_q == 16'(UNIT_CLKS - 1)) begin
        pre_d  = 16'h0000;
        left_d = left_q - 16'h0001;
        if (left_q == 16'h0001) begin
          act_d = 1'b0;
        end
      end else begin
        pre_d = pre_q + 16'h0001;
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pre_q  <= 16'h0000;
      left_q <= 16'h0000;
      act_q  <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      left_q <= left_d;
      act_q  <= act_d;
    end
  end

  assign o_active = act_q;
endmodule
`default_nettype wire

// ==== src/ccmp_top.sv ====
// counter parameter access and multi-value coincidence compare
// assumes counter values arrive synchronous to i_clk from the counter core
`timescale 1ns/1ps
`default_nettype none
module ccmp_top
  import ccmp_pkg::*;
#(
  parameter int UNIT_CLKS = UNIT_CYCLES  // shorten in simulation
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [7:0]        i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  input  wire logic [NCH*32-1:0] i_cnt_val,       // live counts, channel 0 low
  output logic [NCH-1:0]         o_coin_out,      // coincidence output per channel
  output logic [NCH-1:0]         o_cmp_event,     // pulse toward user tasks
  output logic [NCH-1:0]         o_dir,           // counting direction, 1 = down
  output logic [NCH-1:0]         o_freq_meas_off, // stop freq_result
  output logic [NCH-1:0]         o_rot_rate_off,  // stop rot_rate_result
  output logic                   o_irq
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_FAULT = 4'b1000
  } cmp_state_e;

  // parameter number to bit position; -1 when unknown
  function automatic int pid_pos(input logic [31:0] pid);
    case (pid)
      PID_EVT_MASK: pid_pos = PB_EVT;
      PID_SOFT_OUT: pid_pos = PB_SOFT;
      PID_DIR:      pid_pos = PB_DIR;
      PID_FREQ_OFF: pid_pos = PB_FREQ;
      PID_ROT_OFF:  pid_pos = PB_ROT;
      default:      pid_pos = -1;
    endcase
  endfunction

  // clip a unit count to the 3000 ms ceiling
  function automatic logic [15:0] clip_len(input logic [15:0] u);
    clip_len = (u > MAX_UNITS) ? MAX_UNITS : u;
  endfunction

  logic [7:0]       ctrl_q, ctrl_d;        // control word
  logic [31:0]      pid_q, pid_d;          // param_id
  logic [31:0]      num_q, num_d;          // entry count as given
  logic [15:0]      plen_q, plen_d;        // direct_hw_pulse_len
  logic [IDX_W-1:0] tidx_q, tidx_d;        // table load pointer
  logic [31:0]      tbl_q [TBL_DEPTH];     // cmp_table
  logic [31:0]      tbl_d [TBL_DEPTH];
  logic [PB_N-1:0]  par_q [NCH];           // per-channel boolean parameters
  logic [PB_N-1:0]  par_d [NCH];
  logic [IRQ_N-1:0] ists_q, ists_d, imask_q, imask_d;
  logic             ack_q, ack_d, irq_q, irq_d;
  logic [31:0]      rdat_q, rdat_d;
  logic             rd_valid_q, rd_valid_d, rd_val_q, rd_val_d;
  logic             wr_done_q, wr_done_d, err_q, err_d;
  logic [15:0]      ecode_q, ecode_d;      // err_code
  logic             wex_prev_q, cen_prev_q;
  cmp_state_e       st_q, st_d;
  logic [CH_W-1:0]  ch_q, ch_d;            // channel under compare
  logic [IDX_W-1:0] idx_q, idx_d, cidx_q, cidx_d;
  logic [31:0]      mcnt_q, mcnt_d;        // match_count
  logic             done_q, done_d, hw_q, hw_d, path_q, path_d, hold_q, hold_d;
  logic [NCH-1:0]   evt_q, evt_d, coin_q, coin_d;
  logic [NCH-1:0]   dir_q, freq_q, rot_q;
  logic             wb_hit, wr_rise, cen_rise, match_fire, tmr_start, tmr_act;
  logic [15:0]      tmr_len;
  logic [31:0]      cur_cnt;
  logic [CH_W-1:0]  sel_ch;
  logic             dir_run;
  int               pos;

  assign wb_hit   = i_wb_cyc & i_wb_stb & ~ack_q;
  assign sel_ch   = ctrl_q[CT_CH_LSB +: CH_W];
  assign wr_rise  = ctrl_q[CT_WR_EX] & ~wex_prev_q;
  assign cen_rise = ctrl_q[CT_CMP_EN] & ~cen_prev_q;
  assign cur_cnt  = i_cnt_val[ch_q*32 +: 32];
  assign dir_run  = par_q[ch_q][PB_DIR];
  // only the current entry is looked at
  assign match_fire = (st_q == ST_RUN) && (cur_cnt == tbl_q[idx_q]);

  // register port, parameter access and interrupt status
  always_comb begin
    ctrl_d = ctrl_q; pid_d = pid_q; num_d = num_q; plen_d = plen_q;
    tidx_d = tidx_q; tbl_d = tbl_q; par_d = par_q; imask_d = imask_q;
    ists_d = ists_q; rdat_d = rdat_q; ack_d = 1'b0;
    rd_valid_d = 1'b0; rd_val_d = 1'b0; wr_done_d = wr_done_q;
    err_d = err_q; ecode_d = ecode_q;
    pos = pid_pos(pid_q);
    if (wb_hit) begin
      ack_d  = 1'b1;
      rdat_d = 32'h0000_0000; // unmapped reads give zero
      if (i_wb_we && i_wb_sel[0]) begin
        case (i_wb_adr)
          REG_CTRL:  ctrl_d  = i_wb_dat[7:0];
          REG_PID:   pid_d   = i_wb_dat;
          REG_NUM:   num_d   = i_wb_dat;
          REG_PLEN:  plen_d  = i_wb_dat[15:0];
          REG_TIDX:  tidx_d  = i_wb_dat[IDX_W-1:0];
          REG_IMASK: imask_d = i_wb_dat[IRQ_N-1:0];
          REG_TDATA: begin
            if (32'(tidx_q) < TBL_DEPTH) begin
              tbl_d[tidx_q] = i_wb_dat;
              tidx_d = tidx_q + 7'h01;
            end
          end
          default: ;
        endcase
      end else if (!i_wb_we) begin
        case (i_wb_adr)
          REG_CTRL:  rdat_d = {24'h000000, ctrl_q};
          REG_PID:   rdat_d = pid_q;
          REG_STAT:  rdat_d = {26'h0, err_q, (st_q == ST_RUN) | (st_q == ST_CHECK),
                               done_q, wr_done_q, rd_val_q, rd_valid_q};
          REG_ECODE: rdat_d = {16'h0000, ecode_q};
          REG_MCNT:  rdat_d = mcnt_q;
          REG_CIDX:  rdat_d = {25'h0, cidx_q};
          REG_NUM:   rdat_d = num_q;
          REG_PLEN:  rdat_d = {16'h0000, plen_q};
          REG_TIDX:  rdat_d = {25'h0, tidx_q};
          REG_ISTS:  rdat_d = {29'h0, ists_q};
          REG_IMASK: rdat_d = {29'h0, imask_q};
          default:   rdat_d = 32'h0000_0000;
        endcase
        if (i_wb_adr == REG_ISTS) begin
          ists_d = '0; // read clears; new events below still win
        end
      end
    end
    // level-held read of one boolean parameter
    if (ctrl_q[CT_RD_EN]) begin
      if (pos >= 0) begin
        rd_valid_d = 1'b1;
        rd_val_d   = par_q[sel_ch][pos];
      end else begin
        err_d = 1'b1; ecode_d = ERR_BAD_PID;
      end
    end
    // write applied once per execute rise; done cleared on release
    if (!ctrl_q[CT_WR_EX]) begin
      wr_done_d = 1'b0;
    end else if (wr_rise) begin
      if (pos < 0) begin
        err_d = 1'b1; ecode_d = ERR_BAD_PID;
      end else if (pos == PB_DIR && st_q != ST_IDLE && st_q != ST_FAULT
                   && ch_q == sel_ch) begin
        err_d = 1'b1; ecode_d = ERR_DIR_LOCK; // direction locked while comparing
      end else begin
        par_d[sel_ch][pos] = ctrl_q[CT_WR_VAL];
        wr_done_d = 1'b1;
        err_d = 1'b0; ecode_d = ERR_NONE;
      end
    end
    // compare unit reports faults through the same flag
    // a fresh start that faults again must refresh the code as well
    if (st_d == ST_FAULT && (st_q != ST_FAULT || cen_rise)) begin
      err_d = 1'b1;
      ecode_d = (num_q == 32'h0 || num_q > 32'(TBL_DEPTH)) ? ERR_BAD_NUM : ERR_BAD_VAL;
    end
    // sticky events; set wins over the read clear
    if (match_fire)               ists_d[IRQ_MATCH] = 1'b1;
    if (wr_done_d && !wr_done_q)  ists_d[IRQ_WDONE] = 1'b1;
    if (err_d && !err_q)          ists_d[IRQ_ERR]   = 1'b1;
    irq_d = |(ists_d & imask_d);
  end

  // compare unit sequencing
  always_comb begin
    st_d = st_q; ch_d = ch_q; idx_d = idx_q; cidx_d = cidx_q; mcnt_d = mcnt_q;
    done_d = done_q; hw_d = hw_q; path_d = path_q; hold_d = hold_q;
    evt_d = '0; tmr_start = 1'b0; tmr_len = 16'h0000;
    case (st_q)
      ST_IDLE, ST_FAULT: begin
        if (cen_rise) begin
          ch_d = sel_ch; idx_d = '0; mcnt_d = 32'h0; done_d = 1'b0;
          hw_d = ctrl_q[CT_HW]; hold_d = 1'b0;
          // count range checked before anything runs
          st_d = (num_q == 32'h0 || num_q > 32'(TBL_DEPTH)) ? ST_FAULT : ST_CHECK;
        end
      end
      ST_CHECK: begin
        // one entry per cycle: no extreme codes, strict order per direction
        if (tbl_q[idx_q] == DINT_MIN || tbl_q[idx_q] == DINT_MAX) begin
          st_d = ST_FAULT;
        end else if (idx_q != '0 &&
                     (dir_run ? ($signed(tbl_q[idx_q]) >= $signed(tbl_q[idx_q-7'h01]))
                              : ($signed(tbl_q[idx_q]) <= $signed(tbl_q[idx_q-7'h01])))) begin
          st_d = ST_FAULT;
        end else if (32'(idx_q) == num_q - 32'h1) begin
          st_d = ST_RUN; idx_d = '0;
        end else begin
          idx_d = idx_q + 7'h01;
        end
      end
      ST_RUN: begin
        if (match_fire) begin
          mcnt_d = mcnt_q + 32'h1;
          cidx_d = idx_q;
          done_d = 1'b1;
          idx_d  = idx_q + 7'h01;
          if (!par_q[ch_q][PB_EVT]) evt_d[ch_q] = 1'b1;
          tmr_start = 1'b1;
          if (hw_q) begin
            path_d  = 1'b1;
            tmr_len = clip_len(plen_q);
          end else begin
            path_d  = ~par_q[ch_q][PB_SOFT];
            hold_d  = ~par_q[ch_q][PB_SOFT] & (plen_q == 16'h0000);
            tmr_len = clip_len(plen_q);
          end
          if (32'(idx_q) == num_q - 32'h1) st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // dropping the enable stops the run and clears the held output
    if (!ctrl_q[CT_CMP_EN]) begin
      if (st_q == ST_RUN || st_q == ST_CHECK) st_d = ST_IDLE;
      done_d = 1'b0; hold_d = 1'b0;
    end
    coin_d = '0;
    if ((tmr_act && path_q) || hold_q) coin_d[ch_q] = 1'b1;
  end

  ccmp_pulse_timer #(
    .UNIT_CLKS (UNIT_CLKS)
  ) u_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (tmr_start),
    .i_units   (tmr_len),
    .o_active  (tmr_act)
  );

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST; pid_q <= 32'h0; num_q <= 32'h0; plen_q <= 16'h0000;
      tidx_q <= '0; ists_q <= '0; imask_q <= '0; ack_q <= 1'b0; irq_q <= 1'b0;
      rdat_q <= 32'h0; rd_valid_q <= 1'b0; rd_val_q <= 1'b0; wr_done_q <= 1'b0;
      err_q <= 1'b0; ecode_q <= ERR_NONE; wex_prev_q <= 1'b0; cen_prev_q <= 1'b0;
      st_q <= ST_IDLE; ch_q <= '0; idx_q <= '0; cidx_q <= '0; mcnt_q <= 32'h0;
      done_q <= 1'b0; hw_q <= 1'b0; path_q <= 1'b0; hold_q <= 1'b0;
      evt_q <= '0; coin_q <= '0; dir_q <= '0; freq_q <= '0; rot_q <= '0;
      for (int i = 0; i < TBL_DEPTH; i++) tbl_q[i] <= 32'h0;
      for (int c = 0; c < NCH; c++) par_q[c] <= PARAM_RST;
    end else begin
      ctrl_q <= ctrl_d; pid_q <= pid_d; num_q <= num_d; plen_q <= plen_d;
      tidx_q <= tidx_d; ists_q <= ists_d; imask_q <= imask_d; ack_q <= ack_d;
      irq_q <= irq_d; rdat_q <= rdat_d; rd_valid_q <= rd_valid_d;
      rd_val_q <= rd_val_d; wr_done_q <= wr_done_d; err_q <= err_d;
      ecode_q <= ecode_d; wex_prev_q <= ctrl_q[CT_WR_EX];
      cen_prev_q <= ctrl_q[CT_CMP_EN]; st_q <= st_d; ch_q <= ch_d; idx_q <= idx_d;
      cidx_q <= cidx_d; mcnt_q <= mcnt_d; done_q <= done_d; hw_q <= hw_d;
      path_q <= path_d; hold_q <= hold_d; evt_q <= evt_d; coin_q <= coin_d;
      tbl_q <= tbl_d; par_q <= par_d;
      for (int c = 0; c < NCH; c++) begin
        dir_q[c]  <= par_d[c][PB_DIR];
        freq_q[c] <= par_d[c][PB_FREQ];
        rot_q[c]  <= par_d[c][PB_ROT];
      end
    end
  end

  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;
  assign o_coin_out = coin_q;
  assign o_cmp_event = evt_q;
  assign o_dir = dir_q;
  assign o_freq_meas_off = freq_q;
  assign o_rot_rate_off = rot_q;
  assign o_irq = irq_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_RD_VALID: assert property (
    ctrl_q[CT_RD_EN] && pid_pos(pid_q) >= 0
    |=> rd_valid_q && rd_val_q == $past(par_q[sel_ch][pid_pos(pid_q)]))
    else $error("read valid or value wrong");
  AST_WR_DONE: assert property (
    $rose(wr_done_q) |-> $past(wr_rise) && $past(ctrl_q[CT_WR_EX]))
    else $error("write done without execute rise");
  AST_EVT_MASK: assert property (
    match_fire |=> evt_q[$past(ch_q)] == !$past(par_q[ch_q][PB_EVT]))
    else $error("compare event not gated by mask");
  AST_SOFT_GATE: assert property (
    match_fire && !hw_q && par_q[ch_q][PB_SOFT] |=> !path_q && !hold_q)
    else $error("soft output driven while gated off");
  AST_DIR_NOW: assert property (
    wr_rise && pid_q == PID_DIR && st_q == ST_IDLE
    |=> ##1 o_dir[$past(sel_ch, 2)] == $past(ctrl_q[CT_WR_VAL], 2))
    else $error("direction not applied at once");
  AST_FREQ_OFF: assert property (
    wr_rise && pid_q == PID_FREQ_OFF
    |=> o_freq_meas_off[$past(sel_ch)] == $past(ctrl_q[CT_WR_VAL]))
    else $error("frequency disable not followed");
  AST_HW_ZERO: assert property (
    match_fire && hw_q && plen_q == 16'h0000 |=> !tmr_act [*2])
    else $error("zero length pulse in direct mode");
  AST_MATCH_CNT: assert property (
    match_fire |=> mcnt_q == $past(mcnt_q) + 32'h1 && cidx_q == $past(idx_q) && done_q)
    else $error("match count or index not updated");
  AST_IDX_ADV: assert property (
    st_q == ST_RUN && !match_fire && ctrl_q[CT_CMP_EN] |=> idx_q == $past(idx_q))
    else $error("table index moved without match");
  AST_ERR_CODE: assert property (
    $rose(err_q) |-> ecode_q != ERR_NONE)
    else $error("error flag without code");
endmodule
`default_nettype wire

// ==== test/ccmp_cnt_model.sv ====
// counter core stand-in: eight counters feeding the compare block
// assumes run comes from the bench and direction from the block itself
`timescale 1ns/1ps
`default_nettype none
module ccmp_cnt_model (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [7:0]   i_run,     // count enable per channel
  input  wire logic [7:0]   i_dir,     // 1 = count down
  output logic      [255:0] o_cnt_val  // channel c at [c*32+:32]
);
  logic [255:0] cnt_d;  // next counts
  logic [255:0] cnt_q;  // held counts
  // a stopped channel drops to zero so every run starts below the table
  always_comb begin
    cnt_d = cnt_q;
    for (int c = 0; c < 8; c++) begin
      if (!i_run[c]) begin
        cnt_d[c*32+:32] = 32'h0000_0000;
      end else if (i_dir[c]) begin
        cnt_d[c*32+:32] = cnt_q[c*32+:32] - 32'h1;  // strictly falling
      end else begin
        cnt_d[c*32+:32] = cnt_q[c*32+:32] + 32'h1;  // strictly rising
      end
    end
  end
  // register stage only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign o_cnt_val = cnt_q;
endmodule
`default_nettype wire

// ==== test/test_counter_param_multi_compare.sv ====
// self-checking bench for the parameter and multi-compare block
// assumes the counter model in its own file and a 4-clock pulse unit
`timescale 1ns/1ps
`default_nettype none
module test_counter_param_multi_compare
  import ccmp_pkg::*;
();
  logic         clk = 1'b0;   // 20 MHz
  logic         rst = 1'b1;   // sync, active high
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat;
  logic         ack;
  logic [255:0] cnt;
  logic [7:0]   coin, evt, dir, frq, rot;
  logic         irq;
  logic [7:0]   run = 8'h00;  // counter enables
  logic [31:0]  q;            // last word read
  int           num_errors = 0;
  int           total_checks = 0;
  int           cycles = 0;
  int           ev_cnt = 0;   // event pulses seen
  int           out_cyc = 0;  // cycles of output high
  int           ev0 = 0;      // event count at run start
  int           oc0 = 0;      // output count at run start
  int           mon = 0;      // watched channel
  always #25 clk = ~clk;
  ccmp_top #(.UNIT_CLKS(4)) u_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_cnt_val(cnt), .o_coin_out(coin),
    .o_cmp_event(evt), .o_dir(dir), .o_freq_meas_off(frq),
    .o_rot_rate_off(rot), .o_irq(irq));
  ccmp_cnt_model u_cnt (.i_clk(clk), .i_sys_rst(rst), .i_run(run),
    .i_dir(dir), .o_cnt_val(cnt));
  // hang guard and output monitor
  always @(posedge clk) begin
    cycles++;
    if (evt[mon] === 1'b1) ev_cnt++;
    if (coin[mon] === 1'b1) out_cyc++;
    if (cycles == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb} <= 2'b11;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // parameter write through the execute edge
  task automatic pw(input int ch, input logic [31:0] pid, input logic v);
    logic [31:0] c;
    c = 32'(ch) | (32'(v) << CT_WR_VAL);
    wb(1'b1, REG_PID, pid);
    wb(1'b1, REG_CTRL, c);
    wb(1'b0, REG_STAT, 32'h0);
    chk("done before execute", q[2], 1'b0);
    wb(1'b1, REG_CTRL, c | 32'h10);
    wb(1'b0, REG_STAT, 32'h0);
    chk("write done", q[2], 1'b1);
    wb(1'b1, REG_CTRL, 32'(ch));
  endtask
  // parameter read while the level enable is held
  task automatic pr(input int ch, input logic [31:0] pid, input logic v);
    wb(1'b1, REG_PID, pid);
    wb(1'b1, REG_CTRL, 32'(ch) | 32'h8);
    wb(1'b0, REG_STAT, 32'h0);
    chk("read value valid", q[1:0], {v, 1'b1});
    wb(1'b1, REG_CTRL, 32'(ch));
    wb(1'b0, REG_STAT, 32'h0);
    chk("valid off", q[0], 1'b0);
  endtask
  // load a rising table in steps of ten and start a compare
  task automatic cmp(input int ch, input logic hw, input int n, input logic [31:0] v0);
    logic [31:0] c;
    c = 32'(ch) | (32'(hw) << CT_HW);
    wb(1'b1, REG_TIDX, 32'h0);
    for (int i = 0; i < n && i < TBL_DEPTH; i++) begin
      wb(1'b1, REG_TDATA, v0 + 32'(i * 10));
    end
    wb(1'b1, REG_NUM, 32'(n));
    wb(1'b1, REG_PLEN, 32'h2);
    wb(1'b1, REG_CTRL, c);
    mon = ch;
    ev0 = ev_cnt;
    oc0 = out_cyc;
    wb(1'b1, REG_CTRL, c | 32'h40);
    run[ch] <= 1'b1;
  endtask
  // wait for all matches, then judge counts, index and outputs
  task automatic done_run(input int ch, input int n, input int ev, input int oc);
    int k;
    k = 0;
    do begin
      wb(1'b0, REG_MCNT, 32'h0);
      k++;
    end while (q !== 32'(n) && k < 60);
    repeat (12) @(posedge clk);
    chk("match count", q, 32'(n));
    wb(1'b0, REG_CIDX, 32'h0);
    chk("index", q, 32'(n - 1));
    wb(1'b0, REG_STAT, 32'h0);
    chk("cmp done", q[3], 1'b1);
    chk("events", 32'(ev_cnt - ev0), 32'(ev));
    chk("output cycles", 32'(out_cyc - oc0), 32'(oc));
    wb(1'b1, REG_CTRL, 32'(ch));
    run[ch] <= 1'b0;
  endtask
  // a refused request leaves flag and code
  task automatic err(input int ch, input logic [15:0] code);
    wb(1'b0, REG_ECODE, 32'h0);
    chk("err code", q, 32'(code));
    wb(1'b0, REG_STAT, 32'h0);
    chk("err flag", q[5], 1'b1);
    wb(1'b1, REG_CTRL, 32'(ch));
    run[ch] <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk("outputs idle", {coin, evt, dir, frq}, 32'h0);
    wb(1'b0, REG_STAT, 32'h0);
    chk("status reset", q, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    pw(2, PID_DIR, 1'b1);
    chk("direction", dir, 8'h04);
    pw(5, PID_FREQ_OFF, 1'b1);
    chk("freq off", frq, 8'h20);
    pw(7, PID_ROT_OFF, 1'b1);
    chk("rot off", rot, 8'h80);
    pr(2, PID_DIR, 1'b1);
    pr(5, PID_FREQ_OFF, 1'b1);
    pr(7, PID_ROT_OFF, 1'b1);
    pr(1, PID_EVT_MASK, 1'b0);
    pr(1, PID_SOFT_OUT, 1'b0);
    pw(2, PID_DIR, 1'b0);
    chk("direction back", dir, 8'h00);
    wb(1'b1, REG_PID, 32'h0000_2713);
    wb(1'b1, REG_CTRL, 32'h10);
    err(0, ERR_BAD_PID);
    cmp(0, 1'b0, 0, 32'hA);
    err(0, ERR_BAD_NUM);
    cmp(0, 1'b0, 101, 32'hA);
    err(0, ERR_BAD_NUM);
    cmp(0, 1'b0, 1, DINT_MAX);
    err(0, ERR_BAD_VAL);
    wb(1'b0, REG_ISTS, 32'h0);
    wb(1'b1, REG_IMASK, 32'h1);
    cmp(1, 1'b0, 3, 32'hA);
    done_run(1, 3, 3, 24);
    chk("irq up", irq, 1'b1);
    wb(1'b0, REG_ISTS, 32'h0);
    chk("irq match bit", q[0], 1'b1);
    wb(1'b0, REG_ISTS, 32'h0);
    chk("irq cleared", {q[0], irq}, 2'b00);
    pw(1, PID_EVT_MASK, 1'b1);
    pw(1, PID_SOFT_OUT, 1'b1);
    cmp(1, 1'b0, 3, 32'hA);
    done_run(1, 3, 0, 0);
    cmp(1, 1'b1, 3, 32'hA);
    done_run(1, 3, 0, 24);
    // a rising table on a down-counting channel is refused at its second entry
    pw(3, PID_DIR, 1'b1);
    cmp(3, 1'b0, 3, 32'hA);
    repeat (4) @(posedge clk);
    err(3, ERR_BAD_VAL);
    finish_test();
  end
endmodule
`default_nettype wire
